// ### core/digital_io_mode_logic.v
`timescale 1ns/1ps
`default_nettype none
`include "dio_map.vh"

module digital_io_mode_logic #(
  parameter VAL_W   = 24,
  parameter TIME_W  = 16,
  parameter DEB_W   = 20,
  parameter DEB_CYC = (`CLK_HZ / 1000) * `TARE_DEBOUNCE_MS
) (
  input  wire              i_mclk,
  input  wire              i_nrst,
  input  wire [7:0]        i_addr,
  input  wire [31:0]       i_wdata,
  input  wire              i_wr,
  input  wire              i_rd,
  output reg  [31:0]       o_rdata,
  output wire              o_irq,
  input  wire              i_trigger_input,
  input  wire              i_tare_input,
  output reg               o_limit_output_a,
  output reg               o_limit_output_b,
  input  wire              i_sample_tick,
  input  wire [VAL_W-1:0]  i_gross,
  input  wire [VAL_W-1:0]  i_net,
  input  wire [VAL_W-1:0]  i_trig_result,
  output reg               o_tare,
  output reg               o_net_select,
  output reg               o_lockout,
  output reg               o_measure,
  output reg               o_capture,
  output reg               o_txd,
  output reg               o_dtr
);

  localparam ST_IDLE = 2'h0;
  localparam ST_LOCK = 2'h1;
  localparam ST_MEAS = 2'h2;

  // ==========================================
  // shared helpers
  function lim_hit;
    input [VAL_W-1:0] val;
    input [VAL_W-1:0] lim;
    begin
      lim_hit = ($signed(val) >= $signed(lim));
    end
  endfunction

  function [15:0] baud_div;
    input [2:0] sel;
    reg   [2:0] s;
    integer     d;
    begin
      s = (sel > `BAUD_SEL_MAX) ? `BAUD_SEL_MAX : sel;
      d = `CLK_HZ / (`BAUD_MIN << s);
      baud_div = d[15:0];
    end
  endfunction

  // ==========================================
  // input synchronisers
  wire trig_lvl;
  wire trig_rise;
  wire tare_lvl;

  in_sync u_trig_sync (
    .i_mclk  (i_mclk),
    .i_nrst  (i_nrst),
    .i_pin   (i_trigger_input),
    .o_level (trig_lvl),
    .o_rise  (trig_rise)
  );

  in_sync u_tare_sync (
    .i_mclk  (i_mclk),
    .i_nrst  (i_nrst),
    .i_pin   (i_tare_input),
    .o_level (tare_lvl),
    .o_rise  ()
  );

  // ==========================================
  // registers
  reg  [`CTRL_W-1:0] ctrl_q;
  reg  [1:0]         port_out_q;
  reg  [VAL_W-1:0]   limit1_q;
  reg  [VAL_W-1:0]   limit2_q;
  reg  [TIME_W-1:0]  lockout_q;
  reg  [TIME_W-1:0]  measure_q;
  reg  [`EV_W-1:0]   status_q;
  reg  [`EV_W-1:0]   mask_q;

  wire control_io_mode = ctrl_q[`CTRL_MODE];
  wire plain_io_mode   = ~control_io_mode;
  wire lim_en          = ctrl_q[`CTRL_LIM_EN];
  wire [1:0] lim_src   = ctrl_q[`CTRL_SRC_HI:`CTRL_SRC_LO];
  wire [2:0] baud_sel  = ctrl_q[`CTRL_BAUD_HI:`CTRL_BAUD_LO];

  wire wr_ctrl    = i_wr & (i_addr == `ADDR_CTRL);
  wire wr_status  = i_wr & (i_addr == `ADDR_STATUS);
  wire wr_tx      = i_wr & (i_addr == `ADDR_TXDATA);

  wire tare_fire;
  wire run_start;
  wire run_done;
  wire tx_done;
  wire tx_busy;
  reg  [1:0] run_st_q;

  always @(posedge i_mclk) begin
    if (!i_nrst) begin
      ctrl_q     <= `CTRL_RST;
      port_out_q <= 2'h0;
      limit1_q   <= {VAL_W{1'b0}};
      limit2_q   <= {VAL_W{1'b0}};
      lockout_q  <= {TIME_W{1'b0}};
      measure_q  <= {TIME_W{1'b0}};
      mask_q     <= `EV_RST;
    end else begin
      if (wr_ctrl) begin
        ctrl_q <= i_wdata[`CTRL_W-1:0];
      end
      if (tare_fire) begin
        ctrl_q[`CTRL_NET_SEL] <= 1'b1;
      end
      if (i_wr && i_addr == `ADDR_PORT_OUT) begin
        port_out_q <= i_wdata[1:0];
      end
      if (i_wr && i_addr == `ADDR_LIMIT1) begin
        limit1_q <= i_wdata[VAL_W-1:0];
      end
      if (i_wr && i_addr == `ADDR_LIMIT2) begin
        limit2_q <= i_wdata[VAL_W-1:0];
      end
      if (i_wr && i_addr == `ADDR_LOCKOUT) begin
        lockout_q <= i_wdata[TIME_W-1:0];
      end
      if (i_wr && i_addr == `ADDR_MEASURE) begin
        measure_q <= i_wdata[TIME_W-1:0];
      end
      if (i_wr && i_addr == `ADDR_MASK) begin
        mask_q <= i_wdata[`EV_W-1:0];
      end
    end
  end

  // ==========================================
  // sticky events, a new event wins over a clear
  wire [`EV_W-1:0] ev_set = {tx_done, run_done, tare_fire, run_start};
  wire [`EV_W-1:0] ev_clr = wr_status ? i_wdata[`EV_W-1:0] : `EV_RST;

  always @(posedge i_mclk) begin
    if (!i_nrst) begin
      status_q <= `EV_RST;
    end else begin
      status_q <= (status_q & ~ev_clr) | ev_set;
    end
  end

  assign o_irq = |(status_q & mask_q);

  // ==========================================
  // read port, data one cycle after the strobe
  reg [31:0] rd_d;

  always @* begin
    rd_d = 32'h0;
    case (i_addr)
      `ADDR_CTRL:     rd_d[`CTRL_W-1:0] = ctrl_q;
      `ADDR_PORT_OUT: rd_d[1:0] = port_out_q;
      `ADDR_PORT_IN:  rd_d[1:0] = {tare_lvl, trig_lvl};
      `ADDR_LIMIT1:   rd_d[VAL_W-1:0] = limit1_q;
      `ADDR_LIMIT2:   rd_d[VAL_W-1:0] = limit2_q;
      `ADDR_LOCKOUT:  rd_d[TIME_W-1:0] = lockout_q;
      `ADDR_MEASURE:  rd_d[TIME_W-1:0] = measure_q;
      `ADDR_STATUS:   rd_d[`EV_W-1:0] = status_q;
      `ADDR_MASK:     rd_d[`EV_W-1:0] = mask_q;
      `ADDR_TXDATA:   rd_d[0] = tx_busy;
      `ADDR_STATE:    rd_d[4:0] = {o_limit_output_b, o_limit_output_a, tx_busy, run_st_q};
      default:        rd_d = 32'h0;
    endcase
  end

  always @(posedge i_mclk) begin
    if (!i_nrst) begin
      o_rdata <= 32'h0;
    end else if (i_rd) begin
      o_rdata <= rd_d;
    end else begin
      o_rdata <= 32'h0;
    end
  end

  // ==========================================
  // trigger run: lockout then measurement
  reg [TIME_W-1:0] run_cnt_q;

  assign run_start = control_io_mode & trig_rise & (run_st_q == ST_IDLE);
  assign run_done  = (run_st_q == ST_MEAS) & i_sample_tick & (run_cnt_q >= measure_q);

  always @(posedge i_mclk) begin
    if (!i_nrst) begin
      run_st_q  <= ST_IDLE;
      run_cnt_q <= {TIME_W{1'b0}};
    end else begin
      case (run_st_q)
        ST_IDLE: begin
          run_cnt_q <= {TIME_W{1'b0}};
          if (run_start) begin
            run_st_q <= ST_LOCK;
          end
        end
        ST_LOCK: begin
          if (i_sample_tick) begin
            if (run_cnt_q >= lockout_q) begin
              run_st_q  <= ST_MEAS;
              run_cnt_q <= {TIME_W{1'b0}};
            end else begin
              run_cnt_q <= run_cnt_q + 1'b1;
            end
          end
        end
        ST_MEAS: begin
          if (run_done) begin
            run_st_q <= ST_IDLE;
          end else if (i_sample_tick) begin
            run_cnt_q <= run_cnt_q + 1'b1;
          end
        end
        default: begin
          run_st_q <= ST_IDLE;
        end
      endcase
    end
  end

  always @(posedge i_mclk) begin
    if (!i_nrst) begin
      o_lockout <= 1'b0;
      o_measure <= 1'b0;
      o_capture <= 1'b0;
    end else begin
      o_lockout <= (run_st_q == ST_LOCK);
      o_measure <= (run_st_q == ST_MEAS);
      o_capture <= run_done;
    end
  end

  // ==========================================
  // tare debounce
  reg [DEB_W-1:0] deb_cnt_q;
  reg             deb_done_q;

  assign tare_fire = control_io_mode & ~tare_lvl & ~deb_done_q
                   & (deb_cnt_q == DEB_CYC[DEB_W-1:0] - 1'b1);

  always @(posedge i_mclk) begin
    if (!i_nrst) begin
      deb_cnt_q  <= {DEB_W{1'b0}};
      deb_done_q <= 1'b0;
    end else if (tare_lvl || plain_io_mode) begin
      deb_cnt_q  <= {DEB_W{1'b0}};
      deb_done_q <= 1'b0;
    end else if (tare_fire) begin
      deb_done_q <= 1'b1;
    end else if (!deb_done_q) begin
      deb_cnt_q <= deb_cnt_q + 1'b1;
    end
  end

  always @(posedge i_mclk) begin
    if (!i_nrst) begin
      o_tare       <= 1'b0;
      o_net_select <= 1'b0;
    end else begin
      o_tare       <= tare_fire;
      o_net_select <= ctrl_q[`CTRL_NET_SEL] | tare_fire;
    end
  end

  // ==========================================
  // limit monitoring and output pins
  reg [VAL_W-1:0] lim_val;

  always @* begin
    case (lim_src)
      `SRC_GROSS: lim_val = i_gross;
      `SRC_NET:   lim_val = i_net;
      `SRC_TRIG:  lim_val = i_trig_result;
      default:    lim_val = i_gross;
    endcase
  end

  always @(posedge i_mclk) begin
    if (!i_nrst) begin
      o_limit_output_a <= 1'b0;
      o_limit_output_b <= 1'b0;
    end else if (lim_en) begin
      o_limit_output_a <= lim_hit(lim_val, limit1_q);
      o_limit_output_b <= lim_hit(lim_val, limit2_q);
    end else begin
      o_limit_output_a <= port_out_q[0];
      o_limit_output_b <= port_out_q[1];
    end
  end

  // ==========================================
  // serial transmitter with driver enable
  reg [9:0]  tx_sh_q;
  reg [3:0]  tx_bits_q;
  reg [15:0] tx_baud_q;

  assign tx_busy = (tx_bits_q != 4'h0);
  assign tx_done = tx_busy & (tx_baud_q == 16'h0) & (tx_bits_q == 4'h1);

  always @(posedge i_mclk) begin
    if (!i_nrst) begin
      tx_sh_q   <= `TX_IDLE_FRAME;
      tx_bits_q <= 4'h0;
      tx_baud_q <= 16'h0;
    end else if (!tx_busy) begin
      if (wr_tx) begin
        tx_sh_q   <= {1'b1, i_wdata[7:0], 1'b0};
        tx_bits_q <= `TX_FRAME_BITS;
        tx_baud_q <= baud_div(baud_sel) - 1'b1;
      end
    end else if (tx_baud_q == 16'h0) begin
      tx_sh_q   <= {1'b1, tx_sh_q[9:1]};
      tx_bits_q <= tx_bits_q - 1'b1;
      tx_baud_q <= baud_div(baud_sel) - 1'b1;
    end else begin
      tx_baud_q <= tx_baud_q - 1'b1;
    end
  end

  always @(posedge i_mclk) begin
    if (!i_nrst) begin
      o_txd <= 1'b1;
      o_dtr <= 1'b0;
    end else begin
      o_txd <= tx_busy ? tx_sh_q[0] : 1'b1;
      o_dtr <= tx_busy;
    end
  end

endmodule

`default_nettype wire

// ### common/dio_map.vh
`ifndef DIO_MAP_VH
`define DIO_MAP_VH

// ==========================================
// clock and timing
`define CLK_HZ           40000000
`define TARE_DEBOUNCE_MS 20
`define BAUD_MIN         1200
`define BAUD_SEL_MAX     3'h5

// ==========================================
// register byte addresses
`define ADDR_CTRL     8'h00
`define ADDR_PORT_OUT 8'h04
`define ADDR_PORT_IN  8'h08
`define ADDR_LIMIT1   8'h0c
`define ADDR_LIMIT2   8'h10
`define ADDR_LOCKOUT  8'h14
`define ADDR_MEASURE  8'h18
`define ADDR_STATUS   8'h1c
`define ADDR_MASK     8'h20
`define ADDR_TXDATA   8'h24
`define ADDR_STATE    8'h28

// ==========================================
// control register fields
`define CTRL_MODE     0
`define CTRL_LIM_EN   1
`define CTRL_SRC_LO   2
`define CTRL_SRC_HI   3
`define CTRL_BAUD_LO  4
`define CTRL_BAUD_HI  6
`define CTRL_NET_SEL  7
`define CTRL_W        8
`define CTRL_RST      8'h00

// ==========================================
// limit source codes
`define SRC_GROSS 2'h0
`define SRC_NET   2'h1
`define SRC_TRIG  2'h2

// ==========================================
// event bits
`define EV_TRIG   0
`define EV_TARE   1
`define EV_DONE   2
`define EV_TX     3
`define EV_W      4
`define EV_RST    4'h0

// ==========================================
// serial frame
`define TX_FRAME_BITS 4'ha
`define TX_IDLE_FRAME 10'h3ff

`endif

// ### core/in_sync.v
`timescale 1ns/1ps
`default_nettype none

// ==========================================
// two-stage synchroniser with edge detection
module in_sync (
  input  wire i_mclk,
  input  wire i_nrst,
  input  wire i_pin,
  output wire o_level,
  output wire o_rise
);

  reg meta_q;
  reg sync_q;
  reg prev_q;

  always @(posedge i_mclk) begin
    if (!i_nrst) begin
      meta_q <= 1'b1;
      sync_q <= 1'b1;
      prev_q <= 1'b1;
    end else begin
      meta_q <= i_pin;
      sync_q <= meta_q;
      prev_q <= sync_q;
    end
  end

  assign o_level = sync_q;
  assign o_rise  = sync_q & ~prev_q;

endmodule

`default_nettype wire

// ### testbench/dio_chk_asserts.sv
`timescale 1ns/1ps
`default_nettype none
// ==========================================
// port-level checker
module dio_chk (
  input wire logic        i_mclk,
  input wire logic        i_nrst,
  input wire logic        i_rd,
  input wire logic [31:0] o_rdata,
  input wire logic        o_tare,
  input wire logic        o_net_select,
  input wire logic        o_lockout,
  input wire logic        o_measure,
  input wire logic        o_capture,
  input wire logic        o_txd,
  input wire logic        o_dtr
);
  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (!i_nrst);
  AST_RD_IDLE: assert property (!$past(i_rd) |-> o_rdata == 32'h0) else $error("read data outside read slot");
  AST_TARE_ONE: assert property (o_tare |=> !o_tare) else $error("tare pulse too long");
  AST_TARE_NET: assert property (o_tare |=> o_net_select) else $error("tare without net select");
  AST_RUN_EXCL: assert property (!(o_lockout && o_measure)) else $error("lockout and measure together");
  AST_LOCK_MEAS: assert property ($fell(o_lockout) |-> o_measure) else $error("lockout not followed by measure");
  AST_CAP_ONE: assert property (o_capture |=> !o_capture ##1 !o_capture) else $error("capture pulse too long");
  AST_TX_IDLE: assert property (!o_dtr |-> o_txd) else $error("serial line low outside frame");
  AST_TX_START: assert property ($rose(o_dtr) |-> ##[0:1] !o_txd) else $error("no start bit");
  AST_DTR_MIN: assert property ($rose(o_dtr) |=> o_dtr [*8]) else $error("frame too short");
  cover property (o_tare);
  cover property ($fell(o_measure));
  cover property ($rose(o_dtr));
endmodule
bind digital_io_mode_logic dio_chk u_chk (
  .i_mclk       (i_mclk),
  .i_nrst       (i_nrst),
  .i_rd         (i_rd),
  .o_rdata      (o_rdata),
  .o_tare       (o_tare),
  .o_net_select (o_net_select),
  .o_lockout    (o_lockout),
  .o_measure    (o_measure),
  .o_capture    (o_capture),
  .o_txd        (o_txd),
  .o_dtr        (o_dtr)
);
`default_nettype wire

// ### testbench/io_ctl.sv
`timescale 1ns/1ps
`default_nettype none
// ==========================================
// machine controller driving the two input pins
module io_ctl (
  input  wire logic i_mclk,
  output var logic  o_trigger_input,
  output var logic  o_tare_input
);
  initial begin
    o_trigger_input = 1'b1;
    o_tare_input = 1'b1;
  end
  // low then back high: the rising edge starts a run
  task trig_edge;
    @(posedge i_mclk) o_trigger_input <= 1'b0;
    repeat (3) @(posedge i_mclk);
    o_trigger_input <= 1'b1;
  endtask
  task tare_low(input int n);
    @(posedge i_mclk) o_tare_input <= 1'b0;
    repeat (n) @(posedge i_mclk);
    o_tare_input <= 1'b1;
  endtask
endmodule
`default_nettype wire

// ### testbench/tb_top.sv
`timescale 1ns/1ps
`default_nettype none
`include "dio_map.vh"
module tb_top;
  localparam int P = `CLK_HZ / 38400;
  logic i_mclk = 1'b0, i_nrst = 1'b0, i_wr = 1'b0, i_rd = 1'b0, tick = 1'b0;
  logic [7:0] i_addr = 8'h00, b;
  logic [31:0] i_wdata = 32'h0, seed = 32'h8716c4fa, rdata;
  logic signed [23:0] g = 24'h0, n = 24'h0, tr = 24'h0, l1, l2, v;
  logic [9:0] fr;
  wire logic irq, la, lb, tare, nets, lck, meas, cap, txd, dtr, tp, tq;
  int mismatches = 0, checks = 0, cyc = 0, caps = 0, tares = 0, i, k;
  io_ctl pins (.i_mclk(i_mclk), .o_trigger_input(tp), .o_tare_input(tq));
  digital_io_mode_logic #(.DEB_CYC(16)) DUT (
    .i_mclk(i_mclk), .i_nrst(i_nrst), .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd),
    .o_rdata(rdata), .o_irq(irq), .i_trigger_input(tp), .i_tare_input(tq), .o_limit_output_a(la),
    .o_limit_output_b(lb), .i_sample_tick(tick), .i_gross(g), .i_net(n), .i_trig_result(tr),
    .o_tare(tare), .o_net_select(nets), .o_lockout(lck), .o_measure(meas), .o_capture(cap),
    .o_txd(txd), .o_dtr(dtr));
  always #12.5 i_mclk = ~i_mclk;
  always @(posedge i_mclk) begin
    cyc <= cyc + 1;
    tick <= (cyc % 4 == 0);
    if (cap) caps <= caps + 1;
    if (tare) tares <= tares + 1;
    if (cyc == 40000) begin
      mismatches++;
      end_of_test;
    end
  end
  task end_of_test;
    if (mismatches == 0 && checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  task chk(input logic [31:0] s, input logic [31:0] e);
    checks++;
    if (s !== e) begin
      mismatches++;
      $display("CHECK FAILED at %0t seen %h expected %h", $time, s, e);
    end
  endtask
  function void rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
  endfunction
  task wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge i_mclk);
    i_wr <= 1'b1;
    i_addr <= a;
    i_wdata <= d;
    @(posedge i_mclk);
    i_wr <= 1'b0;
  endtask
  // read and compare the word in the slot after the strobe
  task rd(input logic [7:0] a, input logic [31:0] e);
    @(posedge i_mclk);
    i_rd <= 1'b1;
    i_addr <= a;
    @(posedge i_mclk);
    i_rd <= 1'b0;
    @(negedge i_mclk);
    chk(rdata, e);
  endtask
  // which: 0 waits for lockout, 1 for the driver enable
  task wait_hi(input int which);
    i = 0;
    while (((which == 0) ? lck : dtr) !== 1'b1 && i < 30) begin
      @(posedge i_mclk);
      i++;
    end
  endtask
  initial begin
    repeat (20) @(posedge i_mclk);
    i_nrst <= 1'b1;
    chk(txd, 1'b1);
    rd(`ADDR_CTRL, 32'h0);
    rd(`ADDR_STATUS, 32'h0);
    rd(`ADDR_STATE, 32'h0);
    rd(`ADDR_PORT_IN, 32'h3);
    rd(8'h3c, 32'h0);
    chk(irq, 1'b0);
    for (k = 0; k < 4; k++) begin
      wr(`ADDR_PORT_OUT, k);
      repeat (2) @(posedge i_mclk);
      chk({lb, la}, k[1:0]);
    end
    fork
      pins.tare_low(20);
      pins.trig_edge;
      begin
        repeat (8) @(posedge i_mclk);
        rd(`ADDR_PORT_IN, 32'h1);
      end
    join
    rd(`ADDR_STATUS, 32'h0);
    for (k = 0; k < 3; k++) begin
      for (int j = 0; j < 4; j++) begin
        rnd;
        l1 = seed[23:0];
        rnd;
        l2 = seed[31:8];
        wr(`ADDR_LIMIT1, {8'h00, l1});
        wr(`ADDR_LIMIT2, {8'h00, l2});
        wr(`ADDR_CTRL, 32'h2 | (k << 2));
        rnd;
        g <= seed[23:0];
        n <= seed[31:8];
        tr <= seed[27:4];
        repeat (3) @(posedge i_mclk);
        v = (k == 0) ? g : (k == 1) ? n : tr;
        chk({lb, la}, {v >= l2, v >= l1});
      end
    end
    wr(`ADDR_CTRL, 32'h0);
    repeat (3) @(posedge i_mclk);
    chk({lb, la}, 2'h3);
    wr(`ADDR_CTRL, 32'h1);
    wr(`ADDR_LOCKOUT, 32'h2);
    wr(`ADDR_MEASURE, 32'h2);
    wr(`ADDR_MASK, 32'h1);
    pins.trig_edge;
    wait_hi(0);
    chk(lck, 1'b1);
    chk(irq, 1'b1);
    pins.trig_edge;
    repeat (60) @(posedge i_mclk);
    chk(caps, 1);
    rd(`ADDR_STATUS, 32'h5);
    wr(`ADDR_STATUS, 32'h1);
    @(negedge i_mclk);
    chk(irq, 1'b0);
    pins.trig_edge;
    repeat (60) @(posedge i_mclk);
    chk(caps, 2);
    wr(`ADDR_STATUS, 32'hf);
    pins.tare_low(8);
    repeat (5) @(posedge i_mclk);
    chk(tares, 0);
    pins.tare_low(40);
    repeat (5) @(posedge i_mclk);
    chk(tares, 1);
    chk(nets, 1'b1);
    rd(`ADDR_CTRL, 32'h81);
    wr(`ADDR_STATUS, 32'hf);
    wr(`ADDR_CTRL, 32'h50);
    rnd;
    b = seed[7:0];
    wr(`ADDR_TXDATA, {24'h0, b});
    wait_hi(1);
    rd(`ADDR_TXDATA, 32'h1);
    wr(`ADDR_TXDATA, {24'h0, ~b});
    repeat (P / 2 - 5) @(posedge i_mclk);
    for (k = 0; k < 10; k++) begin
      fr[k] = txd;
      repeat (P) @(posedge i_mclk);
    end
    chk(fr, {1'b1, b, 1'b0});
    repeat (2 * P) @(posedge i_mclk);
    chk(dtr, 1'b0);
    rd(`ADDR_STATUS, 32'h8);
    end_of_test;
  end
endmodule
`default_nettype wire
